//--- rtl/qs_defines.svh
// Constants of the egress QoS queue scheduler
`ifndef QS_DEFINES_SVH
`define QS_DEFINES_SVH

// Queue indices, top queue has the highest index
`define QS_Q_TOP 2'h3
`define QS_Q_BOTTOM 2'h0
`define QS_NQ 4
`define QS_NPORT 8

// Queue storage
`define QS_QDEPTH 8
`define QS_PTR_W 3
`define QS_CNT_W 4
`define QS_SEQ_W 6
`define QS_HANDLE_W 8

// Reset values
`define QS_MODE_RST QS_MODE_WEIGHTED
`define QS_WGT_RST 16'h8421
`define QS_MAP_RST 16'hfa50
`define QS_CREDIT_RST 4'h0

`endif

//--- rtl/qs_pkg.sv
// Types of the egress QoS queue scheduler
package qs_pkg;
    `include "qs_defines.svh"

    typedef enum logic [1:0] {
        QS_MODE_FCFS,
        QS_MODE_STRICT,
        QS_MODE_WEIGHTED
    } qs_mode_t;

    typedef struct packed {
        logic [`QS_SEQ_W-1:0] seq;
        logic [`QS_HANDLE_W-1:0] handle;
    } qs_entry_t;

    typedef struct packed {
        qs_mode_t mode;
        logic [3:0][3:0] wgt;
        logic [7:0][1:0] map;
        logic [1:0] cur;
        logic [3:0] credit;
        logic [`QS_SEQ_W-1:0] seq;
        logic out_valid;
        logic [`QS_HANDLE_W-1:0] out_handle;
        logic [1:0] out_q;
        logic busy;
    } qs_state_t;

    typedef struct packed {
        logic [`QS_PTR_W-1:0] wptr;
        logic [`QS_PTR_W-1:0] rptr;
        logic [`QS_CNT_W-1:0] count;
    } qs_fifo_state_t;
endpackage

//--- rtl/qs_queue_if.sv
// Connection between the scheduler and one transmit queue
`timescale 1ns/10ps
interface qs_queue_if;
    import qs_pkg::*;
    logic push;
    qs_entry_t wdata;
    logic pop;
    qs_entry_t rdata;
    logic empty;
    logic full;

    modport owner (input push, input wdata, input pop, output rdata, output empty, output full);
    modport user (output push, output wdata, output pop, input rdata, input empty, input full);
endinterface

//--- rtl/qs_queue.sv
// One transmit queue of frame descriptors
`timescale 1ns/10ps
`include "qs_defines.svh"
module qs_queue (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Scheduler side
    qs_queue_if.owner qp
);
    import qs_pkg::*;

    qs_fifo_state_t s_q;
    qs_fifo_state_t s_d;
    qs_entry_t mem [`QS_QDEPTH];

    logic do_push;
    logic do_pop;

    assign do_push = qp.push && !qp.full;
    assign do_pop = qp.pop && !qp.empty;
    assign qp.empty = (s_q.count == `QS_CNT_W'h0);
    assign qp.full = (s_q.count == `QS_CNT_W'(`QS_QDEPTH));
    assign qp.rdata = mem[s_q.rptr];

    always_comb begin
        s_d = s_q;
        if (do_push) begin
            s_d.wptr = s_q.wptr + `QS_PTR_W'h1;
        end
        if (do_pop) begin
            s_d.rptr = s_q.rptr + `QS_PTR_W'h1;
        end
        if (do_push && !do_pop) begin
            s_d.count = s_q.count + `QS_CNT_W'h1;
        end else if (do_pop && !do_push) begin
            s_d.count = s_q.count - `QS_CNT_W'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Storage has no reset; only entries below the count are ever read out
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[s_q.wptr] <= qp.wdata;
        end
    end
endmodule

//--- rtl/qs_scheduler.sv
// Egress QoS classifier and four-queue transmit scheduler
//
// Summary of operation
// - Four transmit queues, top to bottom priority
// - First-come mode sends in arrival order
// - Strict mode serves highest non-empty queue
// - Round robin top down, weight (zero as one) frames each
// - Reset gives round robin, weights 8,4,2,1
// - Each round robin weight set independently
// - Tagged frame queued via priority map
// - Untagged frame uses port static priority
// - Map holds eight entries, any queue
// - Default map pairs priorities into queues
// - Per-port static priority 0-7 or disabled
`timescale 1ns/10ps
`include "qs_defines.svh"
module qs_scheduler (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Frames from the forwarding fabric
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    input wire logic rx_tagged_i,
    input wire logic [2:0] rx_pcp_i,
    input wire logic [2:0] rx_port_i,
    input wire logic [`QS_HANDLE_W-1:0] rx_handle_i,
    // Frames to the port transmitter
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic [`QS_HANDLE_W-1:0] tx_handle_o,
    output logic [1:0] tx_queue_o,
    input wire logic tx_done_i,
    // Configuration
    input wire qs_pkg::qs_mode_t cfg_mode_i,
    input wire logic [3:0][3:0] cfg_weights_i,
    input wire logic [7:0][1:0] cfg_map_i,
    input wire logic [`QS_NPORT-1:0][3:0] cfg_port_prio_i,
    // Status
    output qs_pkg::qs_mode_t active_mode_o,
    output logic [`QS_NQ-1:0] queue_empty_o,
    output logic busy_o
);
    import qs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Queues
    qs_queue_if qif[`QS_NQ]();
    logic [`QS_NQ-1:0] q_empty;
    logic [`QS_NQ-1:0] q_full;
    logic [`QS_NQ-1:0] push_v;
    logic [`QS_NQ-1:0] pop_v;
    qs_entry_t head [`QS_NQ];
    qs_entry_t wentry;

    qs_state_t s_q;
    qs_state_t s_d;

    for (genvar g = 0; g < `QS_NQ; g++) begin : g_queue
        qs_queue u_queue (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .qp(qif[g])
        );
        assign qif[g].push = push_v[g];
        assign qif[g].pop = pop_v[g];
        assign qif[g].wdata = wentry;
        assign q_empty[g] = qif[g].empty;
        assign q_full[g] = qif[g].full;
        assign head[g] = qif[g].rdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Classification
    logic [3:0] port_prio;
    logic [2:0] rx_pri;
    logic [1:0] rx_q;
    logic rx_take;

    assign port_prio = cfg_port_prio_i[rx_port_i];
    // Bit 3 enables the static priority; a disabled port falls back to 0
    assign rx_pri = rx_tagged_i ? rx_pcp_i : (port_prio[3] ? port_prio[2:0] : 3'h0);
    assign rx_q = s_q.map[rx_pri];
    assign rx_ready_o = !q_full[rx_q];
    assign rx_take = rx_valid_i && rx_ready_o && ce_i;
    assign wentry = '{seq: s_q.seq, handle: rx_handle_i};

    ////////////////////////////////////////////////////////////////////////////
    // Scheduling
    logic idle;
    logic pick;
    logic [1:0] sel;
    logic [3:0] new_credit;
    logic [`QS_SEQ_W-1:0] age [`QS_NQ];
    logic [`QS_SEQ_W-1:0] best_age;
    logic [1:0] cand;
    logic found;

    assign idle = !s_q.out_valid && !s_q.busy;

    always_comb begin
        for (int i = 0; i < `QS_NQ; i++) begin
            age[i] = s_q.seq - head[i].seq;
        end
    end

    always_comb begin
        s_d = s_q;
        pick = 1'b0;
        sel = `QS_Q_BOTTOM;
        new_credit = s_q.credit;
        best_age = '0;
        cand = '0;
        found = 1'b0;
        push_v = '0;
        pop_v = '0;

        if (rx_take) begin
            push_v[rx_q] = 1'b1;
            s_d.seq = s_q.seq + `QS_SEQ_W'h1;
        end

        if (s_q.out_valid && tx_ready_i) begin
            s_d.out_valid = 1'b0;
            s_d.busy = 1'b1;
        end
        if (s_q.busy && tx_done_i) begin
            s_d.busy = 1'b0;
        end

        if (idle) begin
            // Snapshot taken only with nothing offered or in flight
            s_d.mode = cfg_mode_i;
            s_d.wgt = cfg_weights_i;
            s_d.map = cfg_map_i;
            if (q_empty != 4'hf) begin
                pick = 1'b1;
                case (s_q.mode)
                    QS_MODE_FCFS: begin
                        // Sequence stamps never alias: total storage is below 2^SEQ_W
                        for (int i = 0; i < `QS_NQ; i++) begin
                            if (!q_empty[i] && (!found || age[i] > best_age)) begin
                                found = 1'b1;
                                best_age = age[i];
                                sel = 2'(i);
                            end
                        end
                    end
                    QS_MODE_STRICT: begin
                        for (int i = 0; i < `QS_NQ; i++) begin
                            if (!q_empty[i]) begin
                                sel = 2'(i);
                            end
                        end
                    end
                    QS_MODE_WEIGHTED: begin
                        if (!q_empty[s_q.cur] && s_q.credit != 4'h0) begin
                            sel = s_q.cur;
                            new_credit = s_q.credit - 4'h1;
                        end else begin
                            // Walk downward with wrap; the fourth step revisits cur
                            for (int i = 1; i <= `QS_NQ; i++) begin
                                cand = s_q.cur - 2'(i);
                                if (!found && !q_empty[cand]) begin
                                    found = 1'b1;
                                    sel = cand;
                                end
                            end
                            // A zero weight is served as one so no queue starves
                            new_credit = (s_q.wgt[sel] == 4'h0) ? 4'h0 : s_q.wgt[sel] - 4'h1;
                        end
                        s_d.cur = sel;
                        s_d.credit = new_credit;
                    end
                    default: begin
                        // Undefined mode falls back to strict order, never offers an empty queue
                        for (int i = 0; i < `QS_NQ; i++) begin
                            if (!q_empty[i]) begin
                                sel = 2'(i);
                            end
                        end
                    end
                endcase
                pop_v[sel] = ce_i;
                s_d.out_valid = 1'b1;
                s_d.out_handle = head[sel].handle;
                s_d.out_q = sel;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '{mode: `QS_MODE_RST, wgt: `QS_WGT_RST, map: `QS_MAP_RST,
                     cur: `QS_Q_BOTTOM, credit: `QS_CREDIT_RST, default: '0};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign tx_valid_o = s_q.out_valid;
    assign tx_handle_o = s_q.out_handle;
    assign tx_queue_o = s_q.out_q;
    assign active_mode_o = s_q.mode;
    assign queue_empty_o = q_empty;
    assign busy_o = s_q.busy;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic [3:0] higher_mask;
    logic fcfs_ok;
    always_comb begin
        higher_mask = 4'hf << (3'(sel) + 3'h1);
        fcfs_ok = 1'b1;
        for (int i = 0; i < `QS_NQ; i++) begin
            if (!q_empty[i] && age[i] > age[sel]) begin
                fcfs_ok = 1'b0;
            end
        end
    end

    sequence s_handoff;
        s_q.out_valid && tx_ready_i && ce_i;
    endsequence

    sequence s_pending;
        idle && (q_empty != 4'hf) && ce_i;
    endsequence

    a_strict_order: assert property (pick && s_q.mode == QS_MODE_STRICT |->
        (~q_empty & higher_mask) == 4'h0) else $error("strict mode skipped a higher queue");
    a_fcfs_oldest: assert property (pick && s_q.mode == QS_MODE_FCFS |-> fcfs_ok)
        else $error("first-come mode did not send the oldest frame");
    a_weight_stay: assert property (pick && s_q.mode == QS_MODE_WEIGHTED
        && !q_empty[s_q.cur] && s_q.credit != 4'h0 && ce_i |=> s_q.out_q == $past(s_q.cur))
        else $error("round robin left a queue with credit");
    a_no_idle: assert property (s_pending |=> s_q.out_valid && s_q.out_q == $past(sel))
        else $error("scheduler idled with a frame queued");
    a_tag_class: assert property (rx_take && rx_tagged_i |-> push_v[s_q.map[rx_pcp_i]])
        else $error("tagged frame pushed to wrong queue");
    a_untag_class: assert property (rx_take && !rx_tagged_i && port_prio[3] |->
        push_v[s_q.map[port_prio[2:0]]]) else $error("untagged frame pushed to wrong queue");
    a_cfg_hold: assert property (!idle && ce_i |=> s_q.mode == $past(s_q.mode)
        && s_q.wgt == $past(s_q.wgt) && s_q.map == $past(s_q.map))
        else $error("configuration changed inside a frame");
    a_frame_hold: assert property (s_handoff ##1 (!tx_done_i)[*2] |-> s_q.busy && !pick)
        else $error("new frame started before the previous one ended");
    a_weight_load: assert property (pick && s_q.mode == QS_MODE_WEIGHTED
        && s_q.credit == 4'h0 && s_q.wgt[sel] != 4'h0 && ce_i
        |=> s_q.credit == $past(s_q.wgt[sel]) - 4'h1)
        else $error("round robin credit not loaded from weight");
endmodule

//--- verification/qs_mac_model.sv
// Port transmitter model: takes descriptors and ends frames
`timescale 1ns/10ps
module qs_mac_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic slow_i,
    // Descriptor handshake
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_handle_i,
    input wire logic [1:0] tx_queue_i,
    output logic tx_ready_o,
    output logic tx_done_o
);
    logic [9:0] seen[$];
    int cnt;
    logic busy;
    // Slow frames stay in flight long enough for the queues behind them to fill
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_ready_o <= 1'b0;
            tx_done_o <= 1'b0;
            busy <= 1'b0;
            cnt <= 0;
        end else begin
            tx_done_o <= 1'b0;
            if (tx_ready_o) begin
                tx_ready_o <= 1'b0;
                busy <= 1'b1;
                cnt <= slow_i ? 40 : 1;
                seen.push_back({tx_queue_i, tx_handle_i});
            end else if (busy) begin
                if (cnt == 0) begin
                    busy <= 1'b0;
                    tx_done_o <= 1'b1;
                end else begin
                    cnt <= cnt - 1;
                end
            end else if (tx_valid_i && !tx_done_o) begin
                tx_ready_o <= 1'b1;
            end
        end
    end
endmodule

//--- verification/qs_scheduler_tb.sv
// Self-checking bench of the egress QoS scheduler
`timescale 1ns/10ps
module qs_scheduler_tb;
    import qs_pkg::*;
    localparam int NB = 14;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic rx_valid = 1'b0;
    logic rx_tagged = 1'b0;
    logic [2:0] rx_pcp = 3'h0;
    logic [2:0] rx_port = 3'h0;
    logic [7:0] rx_handle = 8'h00;
    logic rx_ready, tx_valid, tx_ready, tx_done, busy;
    logic slow = 1'b0;
    logic [7:0] tx_handle;
    logic [1:0] tx_queue;
    logic [3:0] q_empty;
    qs_mode_t mode = QS_MODE_WEIGHTED;
    qs_mode_t act_mode;
    logic [3:0][3:0] wgt = 16'h8421;
    logic [7:0][1:0] map = 16'hfa50;
    logic [7:0][3:0] pprio = 32'h0;
    int n_errors = 0;
    int tests_run = 0;
    logic [1:0] arr_q [NB] = '{0, 3, 1, 2, 3, 0, 2, 1, 3, 3, 2, 1, 3, 2};
    int exp_i[$];
    int p;

    always #2 clk = ~clk;

    qs_scheduler u_dut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .rx_valid_i(rx_valid),
        .rx_ready_o(rx_ready), .rx_tagged_i(rx_tagged), .rx_pcp_i(rx_pcp), .rx_port_i(rx_port),
        .rx_handle_i(rx_handle), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
        .tx_handle_o(tx_handle), .tx_queue_o(tx_queue), .tx_done_i(tx_done),
        .cfg_mode_i(mode), .cfg_weights_i(wgt), .cfg_map_i(map), .cfg_port_prio_i(pprio),
        .active_mode_o(act_mode), .queue_empty_o(q_empty), .busy_o(busy));

    qs_mac_model u_mac (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .tx_valid_i(tx_valid),
        .tx_handle_i(tx_handle), .tx_queue_i(tx_queue), .tx_ready_o(tx_ready),
        .tx_done_o(tx_done));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Caller stands at a rising edge; valid is left high for back-to-back use
    task automatic push(input logic tg, input logic [2:0] pcp, input logic [2:0] port,
                        input logic [7:0] h);
        int n;
        rx_valid <= 1'b1;
        rx_tagged <= tg;
        rx_pcp <= pcp;
        rx_port <= port;
        rx_handle <= h;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            if (rx_ready === 1'b1) break;
        end
        @(posedge clk);
    endtask

    task automatic send_one(input logic tg, input logic [2:0] pcp, input logic [2:0] port,
                            input logic [1:0] q);
        int n;
        int k;
        n = u_mac.seen.size();
        push(tg, pcp, port, 8'(16 + n));
        rx_valid <= 1'b0;
        for (k = 0; k < 30 && u_mac.seen.size() == n; k++) @(posedge clk);
        repeat (4) @(posedge clk);
        check(u_mac.seen[n], {q, 8'(16 + n)});
    endtask

    // Config is latched only while idle, so settle a few cycles first
    task automatic config_set(input qs_mode_t m, input logic [15:0] w, input logic [15:0] mp);
        mode <= m;
        wgt <= w;
        map <= mp;
        repeat (4) @(posedge clk);
        check({8'h0, act_mode}, {8'h0, m});
    endtask

    task automatic batch(input qs_mode_t m, input logic [15:0] w);
        int i, k, cur, base;
        logic [NB-1:0] taken;
        config_set(m, w, 16'hfa50);
        exp_i.delete();
        taken = '0;
        cur = 3;
        while (exp_i.size() < NB) begin
            k = 0;
            for (i = 0; i < NB; i++) begin
                if (m == QS_MODE_FCFS || (m == QS_MODE_STRICT && arr_q[i] == cur) ||
                    (m == QS_MODE_WEIGHTED && arr_q[i] == cur && k < (w[cur*4 +: 4] == 0 ? 1 :
                    int'(w[cur*4 +: 4])))) begin
                    if (!taken[i]) begin
                        taken[i] = 1'b1;
                        exp_i.push_back(i);
                        k++;
                    end
                end
            end
            cur = (cur + 3) % 4;
        end
        base = u_mac.seen.size();
        slow <= 1'b1;
        push(1'b1, 3'h0, 3'h0, 8'hb0);
        for (i = 0; i < NB; i++) push(1'b1, {arr_q[i], 1'b0}, 3'h0, 8'(64 + i));
        rx_valid <= 1'b0;
        // Mode change while the slow frame is in flight must not be taken up
        mode <= (m == QS_MODE_FCFS) ? QS_MODE_STRICT : QS_MODE_FCFS;
        repeat (4) @(posedge clk);
        check({8'h0, act_mode}, {8'h0, m});
        mode <= m;
        for (k = 0; k < 2000 && u_mac.seen.size() < base + NB + 1; k++) @(posedge clk);
        slow <= 1'b0;
        repeat (50) @(posedge clk);
        check(u_mac.seen[base], 10'h0b0);
        for (i = 0; i < NB; i++) begin
            check(u_mac.seen[base + 1 + i], {arr_q[exp_i[i]], 8'(64 + exp_i[i])});
        end
        check({5'h0, q_empty, busy}, {5'h0, 4'hf, 1'b0});
    endtask

    task automatic complete_run();
        $display("Checks: %0d, errors: %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({act_mode, q_empty, busy, tx_valid, 2'b0}, {QS_MODE_WEIGHTED, 4'hf, 4'h0});
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Clock enable low: an offered frame must not be taken
        ce <= 1'b0;
        push(1'b1, 3'h7, 3'h0, 8'hee);
        rx_valid <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({4'h0, q_empty, tx_valid, busy}, {4'h0, 4'hf, 2'b00});
        @(posedge clk);
        ce <= 1'b1;
        for (p = 0; p < 8; p++) send_one(1'b1, 3'(p), 3'h0, 2'(p / 2));
        for (p = 0; p < 8; p++) pprio[p] <= {1'b1, 3'(7 - p)};
        pprio[3] <= 4'h7;
        @(posedge clk);
        for (p = 0; p < 8; p++) begin
            send_one(1'b0, 3'(p), 3'(p), p == 3 ? 2'h0 : 2'((7 - p) / 2));
        end
        config_set(QS_MODE_WEIGHTED, 16'h8421, 16'h1b1b);
        for (p = 0; p < 8; p++) send_one(1'b1, 3'(p), 3'h0, 2'(3 - p % 4));
        batch(QS_MODE_WEIGHTED, 16'h8421);
        batch(QS_MODE_WEIGHTED, 16'h2130);
        batch(QS_MODE_STRICT, 16'h8421);
        batch(QS_MODE_FCFS, 16'h8421);
        complete_run();
    end
endmodule
